//--- rtl/ppc_pkg.sv
// Shared types and constants for the ping and phase control block
package ppc_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned MS_W = 8;

  // Phase timing, in milliseconds
  localparam logic [7:0] T_PING_MS = 8'h41;
  localparam logic [7:0] T_TERMINATE_MS = 8'h1C;
  localparam logic [7:0] T_FIRST_MS = 8'h14;
  localparam logic [7:0] T_EXPIRE_MS = 8'h5A;

  // Removal deadline in cycles; power is cut on the decision cycle itself
  localparam int unsigned T_TERMINATE_CYC = 28 * MS_CYCLES;

  // Attempt limit and end-of-transfer codes that count as failures
  localparam int unsigned ATTEMPT_LIMIT = 3;
  localparam int unsigned ATTEMPT_W = 2;
  localparam logic [7:0] EPT_NO_RESPONSE = 8'h08;
  localparam logic [7:0] EPT_NEG_FAILURE = 8'h0A;

  // Pin inputs synchronised inside the block
  localparam int unsigned PIN_HALF = 0;
  localparam int unsigned PIN_REMOVED = 1;
  localparam int unsigned PIN_FOREIGN = 2;
  localparam int unsigned PIN_N = 3;

  typedef enum logic [2:0] {
    PH_SELECT,
    PH_PING,
    PH_ID_CFG,
    PH_NEGOTIATE,
    PH_CALIBRATE,
    PH_POWER,
    PH_RENEGOTIATE
  } ppc_phase_e;

  typedef enum logic [1:0] {
    PS_RAMP,
    PS_LISTEN,
    PS_RECV
  } ppc_ping_e;

  // Static configuration of the base station
  typedef struct packed {
    logic usb_powered;
    logic low_adapter;
    logic extended_profile;
    logic fod_ext;
  } ppc_cfg_s;

  // One-cycle events from the packet decoder
  typedef struct packed {
    logic start;
    logic end_seen;
    logic ok;
    logic err;
    logic is_ss;
    logic is_ept;
    logic [7:0] ept_code;
  } ppc_rx_s;

  // Timing reference pulses
  typedef struct packed {
    logic rx_start;
    logic rx_end;
    logic rx_preamble;
    logic tx_start;
    logic tx_end;
  } ppc_ref_s;

endpackage

//--- rtl/ppc_ms_timer.sv
// Restartable millisecond timer with its own cycle divider
`timescale 1ns/1ps
module ppc_ms_timer #(
  parameter int unsigned MS_CYCLES = 40000,
  parameter int unsigned MS_W = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic restart_in,
  output logic [MS_W-1:0] elapsed_ms_out
);
  localparam int unsigned DIV_W = $clog2(MS_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);

  logic [DIV_W-1:0] div;

  generate
    if (MS_CYCLES < 2 || MS_W < 7) begin : g_bad
      $error("ppc_ms_timer: divider or width too small");
    end
  endgenerate

  // Divider restarts too, so a restart gives whole milliseconds from here
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div <= '0;
    end else if (restart_in || div == DIV_LAST) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  // Saturates rather than wraps, so a late check still sees expiry
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      elapsed_ms_out <= '0;
    end else if (restart_in) begin
      elapsed_ms_out <= '0;
    end else if (div == DIV_LAST && elapsed_ms_out != '1) begin
      elapsed_ms_out <= elapsed_ms_out + 1'b1;
    end
  end
endmodule // ppc_ms_timer

//--- rtl/ppc_attempt_counter.sv
// Saturating count of unsuccessful attempts by the receiver on the surface
`timescale 1ns/1ps
module ppc_attempt_counter #(
  parameter int unsigned LIMIT = 3,
  parameter int unsigned W = 2
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic fail_in,
  input wire logic clear_in,
  output logic blocked_out
);
  localparam logic [W-1:0] LIMIT_V = W'(LIMIT);

  logic [W-1:0] count;

  generate
    if (LIMIT < 1 || LIMIT >= (1 << W)) begin : g_bad
      $error("ppc_attempt_counter: limit does not fit width");
    end
  endgenerate

  // A failure in the removal cycle still counts, against a fresh start
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= '0;
    end else if (clear_in) begin
      count <= fail_in ? W'(1) : '0;
    end else if (fail_in && count != LIMIT_V) begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      blocked_out <= 1'b0;
    end else if (clear_in) begin
      blocked_out <= fail_in && LIMIT == 1;
    end else begin
      blocked_out <= (count == LIMIT_V) || (fail_in && count == LIMIT_V - 1'b1);
    end
  end
endmodule // ppc_attempt_counter

//--- rtl/ppc_phase_ctrl.sv
// Transmitter phase machine: selection, digital ping and the later phases
`timescale 1ns/1ps
module ppc_phase_ctrl #(
  parameter int unsigned MS_CYCLES = ppc_pkg::MS_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire ppc_pkg::ppc_cfg_s cfg_in,
  input wire ppc_pkg::ppc_rx_s rx_in,
  input wire logic preamble_start_in,
  input wire logic current_half_in,
  input wire logic object_removed_in,
  input wire logic foreign_object_in,
  input wire logic select_ping_in,
  input wire logic id_advance_in,
  input wire logic cfg_done_in,
  input wire logic cfg_neg_in,
  input wire logic neg_done_in,
  input wire logic cal_done_in,
  input wire logic reneg_req_in,
  input wire logic reneg_done_in,
  input wire logic reneg_abort_in,
  input wire logic fod_reduce_in,
  input wire logic abort_in,
  input wire logic fsk_shift_zc_in,
  input wire logic fsk_return_zc_in,
  output ppc_pkg::ppc_phase_e phase_out,
  output logic power_on_out,
  output logic power_reduce_out,
  output logic contract_update_out,
  output logic attempts_blocked_out,
  output ppc_pkg::ppc_ref_s ref_out
);
  import ppc_pkg::*;

  ppc_phase_e next_phase;
  ppc_ping_e ping_sub;
  ppc_ping_e next_ping_sub;
  logic [PIN_N-1:0] pin_s1;
  logic [PIN_N-1:0] pin_s2;
  logic [PIN_N-1:0] pin_s3;
  logic [PIN_N-1:0] pin_clean;
  logic half_seen;
  logic removed_q;
  logic removal;
  logic foreign;
  logic [MS_W-1:0] elapsed_ms;
  logic timer_restart;
  logic blocked;
  logic ext_ok;
  logic rx_good;
  logic c_window;
  logic c_ss;
  logic c_first;
  logic c_other;
  logic fail_event;
  ppc_phase_e power_target;

  // Pin inputs: a change counts once the second and third stages agree
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_clean <= '0;
      removed_q <= 1'b0;
    end else begin
      pin_s1 <= {foreign_object_in, object_removed_in, current_half_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_clean <= (pin_s2 & pin_s3) | (pin_clean & (pin_s2 | pin_s3));
      removed_q <= pin_clean[PIN_REMOVED];
    end
  end

  assign half_seen = pin_clean[PIN_HALF];
  assign foreign = pin_clean[PIN_FOREIGN];
  assign removal = pin_clean[PIN_REMOVED] && !removed_q;

  // Restart at the window start and at every received start and end
  assign timer_restart = (phase_out == PH_PING && ping_sub == PS_RAMP && half_seen)
                         || rx_in.start || rx_in.end_seen;

  ppc_ms_timer #(
    .MS_CYCLES(MS_CYCLES),
    .MS_W(MS_W)
  ) u_timer (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .restart_in(timer_restart),
    .elapsed_ms_out(elapsed_ms)
  );

  assign rx_good = rx_in.end_seen && rx_in.ok;
  assign fail_event = rx_good && rx_in.is_ept
                      && (rx_in.ept_code == EPT_NO_RESPONSE || rx_in.ept_code == EPT_NEG_FAILURE
                          || phase_out == PH_POWER);

  ppc_attempt_counter #(
    .LIMIT(ATTEMPT_LIMIT),
    .W(ATTEMPT_W)
  ) u_attempts (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .fail_in(fail_event),
    .clear_in(removal),
    .blocked_out(blocked)
  );

  assign ext_ok = cfg_in.extended_profile && cfg_in.fod_ext;
  assign power_target = (cfg_in.usb_powered && blocked) ? PH_SELECT : PH_POWER;

  // Ping conditions, each evaluated only while the ping is still open
  assign c_window = phase_out == PH_PING && ping_sub == PS_LISTEN
                    && elapsed_ms >= T_PING_MS && !rx_in.start;
  assign c_ss = phase_out == PH_PING && ping_sub != PS_RAMP && rx_good && rx_in.is_ss;
  assign c_first = phase_out == PH_PING && ping_sub == PS_RECV
                   && ((elapsed_ms >= T_FIRST_MS && !rx_good) || rx_in.err);
  assign c_other = phase_out == PH_PING && ping_sub != PS_RAMP && rx_good && !rx_in.is_ss;

  always_comb begin
    next_phase = phase_out;
    case (phase_out)
      PH_SELECT: begin
        if (select_ping_in && !foreign && !(cfg_in.low_adapter && blocked)) begin
          next_phase = PH_PING;
        end
      end
      PH_PING: begin
        // Earlier conditions take precedence; no advance means selection
        if (c_window) begin
          next_phase = PH_SELECT;
        end else if (c_ss) begin
          next_phase = id_advance_in ? PH_ID_CFG : PH_SELECT;
        end else if (c_first || c_other) begin
          next_phase = PH_SELECT;
        end
      end
      PH_ID_CFG: begin
        if (abort_in) begin
          next_phase = PH_SELECT;
        end else if (cfg_done_in) begin
          next_phase = (cfg_neg_in && ext_ok) ? PH_NEGOTIATE : power_target;
        end
      end
      PH_NEGOTIATE: begin
        if (foreign || abort_in) begin
          next_phase = PH_SELECT;
        end else if (neg_done_in) begin
          next_phase = PH_CALIBRATE;
        end
      end
      PH_CALIBRATE: begin
        // Two load reports from the receiver are counted upstream
        if (abort_in) begin
          next_phase = PH_SELECT;
        end else if (cal_done_in) begin
          next_phase = power_target;
        end
      end
      PH_POWER: begin
        if (abort_in || (rx_good && rx_in.is_ept) || (foreign && !fod_reduce_in)) begin
          next_phase = PH_SELECT;
        end else if (reneg_req_in && ext_ok) begin
          next_phase = PH_RENEGOTIATE;
        end
      end
      PH_RENEGOTIATE: begin
        if (abort_in) begin
          next_phase = PH_SELECT;
        end else if (reneg_done_in || reneg_abort_in) begin
          next_phase = PH_POWER;
        end
      end
      default: begin
        next_phase = PH_SELECT;
      end
    endcase
  end

  always_comb begin
    next_ping_sub = ping_sub;
    case (ping_sub)
      PS_RAMP: begin
        if (phase_out == PH_PING && half_seen) begin
          next_ping_sub = PS_LISTEN;
        end
      end
      PS_LISTEN: begin
        if (rx_in.start) begin
          next_ping_sub = PS_RECV;
        end
      end
      PS_RECV: begin
        if (rx_good) begin
          next_ping_sub = PS_LISTEN;
        end
      end
      default: begin
        next_ping_sub = PS_RAMP;
      end
    endcase
    if (next_phase != PH_PING) begin
      next_ping_sub = PS_RAMP;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_out <= PH_SELECT;
      ping_sub <= PS_RAMP;
    end else begin
      phase_out <= next_phase;
      ping_sub <= next_ping_sub;
    end
  end

  // Power is cut on the decision cycle, far inside any removal deadline
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      power_on_out <= 1'b0;
    end else begin
      power_on_out <= next_phase != PH_SELECT;
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      power_reduce_out <= 1'b0;
    end else if (next_phase != PH_POWER) begin
      power_reduce_out <= 1'b0;
    end else if (foreign && fod_reduce_in) begin
      power_reduce_out <= 1'b1;
    end
  end
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      contract_update_out <= 1'b0;
    end else begin
      contract_update_out <= phase_out == PH_RENEGOTIATE && !abort_in
                             && reneg_done_in && !reneg_abort_in;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      attempts_blocked_out <= 1'b0;
      ref_out <= '0;
    end else begin
      attempts_blocked_out <= blocked;
      ref_out.rx_start <= rx_in.start;
      ref_out.rx_end <= rx_in.end_seen;
      ref_out.rx_preamble <= preamble_start_in;
      ref_out.tx_start <= fsk_shift_zc_in;
      ref_out.tx_end <= fsk_return_zc_in;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_ping_entry;
    phase_out == PH_SELECT ##1 phase_out == PH_PING;
  endsequence
  sequence s_removed_now;
    phase_out == PH_SELECT && !power_on_out;
  endsequence

  select_no_power_a: assert property (phase_out == PH_SELECT |-> !power_on_out)
    else $error("power applied in selection");
  ping_power_on_a: assert property (s_ping_entry |-> power_on_out)
    else $error("ping entered without power");
  ping_window_a: assert property (c_window |=> s_removed_now)
    else $error("ping window expiry did not remove power");
  strength_adv_a: assert property (c_ss && !c_window |=> power_on_out == $past(id_advance_in)
                                   && phase_out == ($past(id_advance_in) ? PH_ID_CFG : PH_SELECT))
    else $error("strength packet outcome wrong");
  first_late_a: assert property (phase_out == PH_PING && ping_sub == PS_RECV && elapsed_ms > T_FIRST_MS
                                 |-> 1'b0)
    else $error("first packet timeout missed");
  other_pkt_a: assert property (c_other && !c_window |=> s_removed_now)
    else $error("other packet in ping kept power");
  ping_prio_a: assert property (c_window && c_ss |=> phase_out == PH_SELECT)
    else $error("ping priority violated");
  ping_exit_a: assert property (phase_out == PH_PING && next_phase != PH_PING |=>
                                phase_out inside {PH_ID_CFG, PH_SELECT})
    else $error("ping left to a wrong phase");
  ignore_after_a: assert property (phase_out == PH_PING ##1 phase_out == PH_SELECT |->
                                   ping_sub == PS_RAMP)
    else $error("ping state kept after decision");
  ref_pulse_a: assert property (rx_in.start |=> ref_out.rx_start && elapsed_ms == '0)
    else $error("receive start reference missed");
  ext_phase_a: assert property (phase_out inside {PH_NEGOTIATE, PH_CALIBRATE, PH_RENEGOTIATE}
                                |-> $past(ext_ok) || ext_ok)
    else $error("extended phase without extensions");
  usb_block_a: assert property (cfg_in.usb_powered && blocked && phase_out != PH_POWER
                                && phase_out != PH_RENEGOTIATE |=> phase_out != PH_POWER)
    else $error("transfer entered while blocked");
  weak_block_a: assert property (cfg_in.low_adapter && blocked && phase_out == PH_SELECT
                                 |=> phase_out == PH_SELECT)
    else $error("ping entered while blocked");
  foreign_sel_a: assert property (phase_out == PH_SELECT && foreign |=> !power_on_out)
    else $error("power applied with foreign object");
  foreign_neg_a: assert property (phase_out == PH_NEGOTIATE && foreign |=> s_removed_now)
    else $error("negotiation kept power with foreign object");
  foreign_xfer_a: assert property (phase_out == PH_POWER && foreign |=> power_reduce_out || !power_on_out
                                   || phase_out == PH_RENEGOTIATE)
    else $error("foreign object in transfer ignored");
  reneg_abort_a: assert property (phase_out == PH_RENEGOTIATE && reneg_abort_in && !abort_in
                                  |=> phase_out == PH_POWER && !contract_update_out)
    else $error("renegotiation abort changed contract");
  removal_clear_a: assert property (removal |-> ##[1:2] !blocked)
    else $error("removal did not clear attempts");
endmodule // ppc_phase_ctrl

//--- verification/ppc_rx_model.sv
// Power receiver model: packet events as the decoder would report them
`timescale 1ns/1ps
module ppc_rx_model (
  input wire logic clk_in,
  output ppc_pkg::ppc_rx_s rx_out,
  output logic preamble_out
);
  import ppc_pkg::*;
  initial begin
    rx_out = '0;
    preamble_out = 1'b0;
  end
  // Mode 0 ends in a decode error, 1 ends cleanly, 2 never ends
  task automatic send(input int gap, input int len, input int mode, input logic ss, input logic ept,
                      input logic [7:0] code);
    @(posedge clk_in);
    preamble_out <= 1'b1;
    @(posedge clk_in);
    preamble_out <= 1'b0;
    repeat (gap) @(posedge clk_in);
    rx_out.start <= 1'b1;
    @(posedge clk_in);
    rx_out.start <= 1'b0;
    if (mode != 2) begin
      repeat (len) @(posedge clk_in);
      rx_out <= '{1'b0, mode == 1, mode == 1, mode == 0, ss, ept, code};
      @(posedge clk_in);
      // Qualifiers go stale after the end pulse, so show their inverse
      rx_out <= '{1'b0, 1'b0, mode != 1, 1'b0, !ss, !ept, ~code};
    end
  endtask
endmodule // ppc_rx_model

//--- verification/ptx_ping_phase_control_test.sv
// Self-checking bench for the ping and phase control block
`timescale 1ns/1ps
module ptx_ping_phase_control_test;
  import ppc_pkg::*;
  localparam int unsigned MS = 40;
  localparam int C_CFG = 0, C_NEG = 1, C_CAL = 2, C_RQ = 3, C_RD = 4, C_RA = 5, C_AB = 6, C_SEL = 7;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  ppc_cfg_s cfg_in = '0;
  ppc_rx_s rx_in;
  logic preamble_in;
  logic [7:0] ctl = '0;
  logic [2:0] pin = '0;
  logic cfg_neg_in = 1'b0, id_advance_in = 1'b0, fod_reduce_in = 1'b0;
  logic shift_in = 1'b0, return_in = 1'b0, fsk_en = 1'b0;
  ppc_phase_e phase_out;
  logic power_on_out, power_reduce_out, contract_update_out, attempts_blocked_out;
  ppc_ref_s ref_out, ref_exp;
  int n_fail = 0, cmp_count = 0, cycles = 0, kind;

  ppc_phase_ctrl #(.MS_CYCLES(MS)) ppc_phase_ctrl_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .cfg_in(cfg_in), .rx_in(rx_in),
    .preamble_start_in(preamble_in), .current_half_in(pin[PIN_HALF]), .object_removed_in(pin[PIN_REMOVED]),
    .foreign_object_in(pin[PIN_FOREIGN]), .select_ping_in(ctl[C_SEL]), .id_advance_in(id_advance_in),
    .cfg_done_in(ctl[C_CFG]), .cfg_neg_in(cfg_neg_in), .neg_done_in(ctl[C_NEG]), .cal_done_in(ctl[C_CAL]),
    .reneg_req_in(ctl[C_RQ]), .reneg_done_in(ctl[C_RD]), .reneg_abort_in(ctl[C_RA]),
    .fod_reduce_in(fod_reduce_in), .abort_in(ctl[C_AB]), .fsk_shift_zc_in(shift_in),
    .fsk_return_zc_in(return_in), .phase_out(phase_out), .power_on_out(power_on_out),
    .power_reduce_out(power_reduce_out), .contract_update_out(contract_update_out),
    .attempts_blocked_out(attempts_blocked_out), .ref_out(ref_out));

  ppc_rx_model ppc_rx_model_inst (.clk_in(clk_in), .rx_out(rx_in), .preamble_out(preamble_in));

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  // Modulator zero-crossing pulses at random, held off around reset
  always @(posedge clk_in) begin
    shift_in <= fsk_en && ($urandom_range(0, 7) == 0);
    return_in <= fsk_en && ($urandom_range(0, 7) == 0);
  end

  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) ref_exp <= '0;
    else ref_exp <= {rx_in.start, rx_in.end_seen, preamble_in, shift_in, return_in};
  end

  always @(negedge clk_in) begin
    if (reset_n_in) check(ref_out, ref_exp, "reference");
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic ppc_phase_e exp_phase(input int k);
    return (k == 0) ? PH_ID_CFG : PH_SELECT;
  endfunction

  task automatic expect_ph(input ppc_phase_e ph, input logic pw);
    #1;
    check(phase_out, ph, "phase");
    check(power_on_out, pw, "power");
  endtask

  task automatic pulse(input int i);
    @(posedge clk_in);
    ctl[i] <= 1'b1;
    @(posedge clk_in);
    ctl[i] <= 1'b0;
  endtask

  // Pins pass a synchroniser, so allow a few cycles
  task automatic set_pin(input int i, input logic v);
    @(posedge clk_in);
    pin[i] <= v;
    repeat (6) @(posedge clk_in);
  endtask

  task automatic reset_dut(input logic [3:0] c);
    @(posedge clk_in);
    fsk_en <= 1'b0;
    reset_n_in <= 1'b0;
    cfg_in <= c;
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    expect_ph(PH_SELECT, 1'b0);
    check(attempts_blocked_out, 1'b0, "blocked");
    repeat (2) @(posedge clk_in);
    fsk_en <= 1'b1;
  endtask

  task automatic start_ping();
    set_pin(PIN_HALF, 1'b0);
    pulse(C_SEL);
    expect_ph(PH_PING, 1'b1);
    set_pin(PIN_HALF, 1'b1);
  endtask

  task automatic to_id();
    @(posedge clk_in);
    id_advance_in <= 1'b1;
    start_ping();
    ppc_rx_model_inst.send($urandom_range(0, 3), $urandom_range(1, 19 * MS), 1, 1'b1, 1'b0, 8'h00);
    expect_ph(PH_ID_CFG, 1'b1);
  endtask

  initial begin
    void'($urandom(47));
    reset_dut(4'b0000);
    // Silent receiver: the ping holds for the whole window, then lapses
    start_ping();
    repeat (64 * MS) @(posedge clk_in);
    expect_ph(PH_PING, 1'b1);
    repeat (2 * MS) @(posedge clk_in);
    expect_ph(PH_SELECT, 1'b0);
    for (int i = 0; i < 8; i++) begin
      kind = $urandom_range(0, 3);
      @(posedge clk_in);
      id_advance_in <= (kind == 0);
      start_ping();
      ppc_rx_model_inst.send($urandom_range(0, 3), $urandom_range(1, 19 * MS), (kind == 3) ? 0 : 1,
                             kind < 2, kind == 2, 8'h55);
      expect_ph(exp_phase(kind), kind == 0);
      if (kind == 0) begin
        pulse(C_AB);
        expect_ph(PH_SELECT, 1'b0);
      end else begin
        ppc_rx_model_inst.send(0, 4, 1, 1'b1, 1'b0, 8'h00);
        expect_ph(PH_SELECT, 1'b0);
      end
    end
    // First packet starts but never completes
    start_ping();
    ppc_rx_model_inst.send(0, 0, 2, 1'b1, 1'b0, 8'h00);
    repeat (19 * MS) @(posedge clk_in);
    expect_ph(PH_PING, 1'b1);
    repeat (2 * MS) @(posedge clk_in);
    expect_ph(PH_SELECT, 1'b0);
    set_pin(PIN_FOREIGN, 1'b1);
    pulse(C_SEL);
    expect_ph(PH_SELECT, 1'b0);
    set_pin(PIN_FOREIGN, 1'b0);
    // Weak adapter: only the two failure codes count towards the limit
    reset_dut(4'b0100);
    for (int i = 0; i < 4; i++) begin
      start_ping();
      ppc_rx_model_inst.send(1, 8, 1, 1'b0, 1'b1, (i == 1) ? 8'($urandom_range(16, 255)) :
                             (i == 2) ? EPT_NEG_FAILURE : EPT_NO_RESPONSE);
      expect_ph(PH_SELECT, 1'b0);
      repeat (2) @(posedge clk_in);
      #1;
      check(attempts_blocked_out, i == 3, "blocked");
    end
    pulse(C_SEL);
    expect_ph(PH_SELECT, 1'b0);
    set_pin(PIN_REMOVED, 1'b1);
    #1;
    check(attempts_blocked_out, 1'b0, "blocked");
    set_pin(PIN_REMOVED, 1'b0);
    start_ping();
    ppc_rx_model_inst.send(0, 6, 0, 1'b1, 1'b0, 8'h00);
    expect_ph(PH_SELECT, 1'b0);
    // Extended profile with extensions: every phase is reachable
    reset_dut(4'b0011);
    @(posedge clk_in);
    cfg_neg_in <= 1'b1;
    to_id();
    pulse(C_CFG);
    expect_ph(PH_NEGOTIATE, 1'b1);
    set_pin(PIN_FOREIGN, 1'b1);
    expect_ph(PH_SELECT, 1'b0);
    set_pin(PIN_FOREIGN, 1'b0);
    to_id();
    pulse(C_CFG);
    pulse(C_NEG);
    expect_ph(PH_CALIBRATE, 1'b1);
    pulse(C_CAL);
    expect_ph(PH_POWER, 1'b1);
    pulse(C_RQ);
    expect_ph(PH_RENEGOTIATE, 1'b1);
    pulse(C_RA);
    expect_ph(PH_POWER, 1'b1);
    check(contract_update_out, 1'b0, "contract");
    pulse(C_RQ);
    pulse(C_RD);
    expect_ph(PH_POWER, 1'b1);
    check(contract_update_out, 1'b1, "contract");
    @(posedge clk_in);
    fod_reduce_in <= 1'b1;
    set_pin(PIN_FOREIGN, 1'b1);
    expect_ph(PH_POWER, 1'b1);
    check(power_reduce_out, 1'b1, "reduce");
    set_pin(PIN_FOREIGN, 1'b0);
    @(posedge clk_in);
    fod_reduce_in <= 1'b0;
    set_pin(PIN_FOREIGN, 1'b1);
    expect_ph(PH_SELECT, 1'b0);
    set_pin(PIN_FOREIGN, 1'b0);
    // Extended profile without extensions skips negotiation
    reset_dut(4'b0010);
    to_id();
    pulse(C_CFG);
    expect_ph(PH_POWER, 1'b1);
    pulse(C_RQ);
    expect_ph(PH_POWER, 1'b1);
    // USB supply: three ended transfers bar the next one
    reset_dut(4'b1000);
    for (int i = 0; i < 4; i++) begin
      to_id();
      pulse(C_CFG);
      expect_ph((i < 3) ? PH_POWER : PH_SELECT, i < 3);
      if (i < 3) begin
        ppc_rx_model_inst.send(0, 8, 1, 1'b0, 1'b1, 8'($urandom_range(16, 255)));
        repeat (2) @(posedge clk_in);
        #1;
        check(attempts_blocked_out, i == 2, "blocked");
      end
    end
    complete_run();
  end
endmodule // ptx_ping_phase_control_test
